// ### core/cass_pkg.sv
`default_nettype none
package cass_pkg;

    localparam int unsigned CLK_HZ           = 100000000;
    localparam int unsigned PHASE_DEF_MS     = 1000;
    localparam logic [31:0] PHASE_DEF_CYC    = 32'(CLK_HZ / 1000 * PHASE_DEF_MS);
    localparam logic [6:0]  CURRENT_DEF_PCT  = 7'h64;
    localparam logic [6:0]  CURRENT_MAX_PCT  = 7'h64;
    localparam logic        DIR_DEF          = 1'b0;

    localparam logic [3:0]  ADDR_CTRL        = 4'h0;
    localparam logic [3:0]  ADDR_CURRENT     = 4'h1;
    localparam logic [3:0]  ADDR_LOCK_TIME   = 4'h2;
    localparam logic [3:0]  ADDR_LOCK_DELAY  = 4'h3;
    localparam logic [3:0]  ADDR_MOVE_TIME   = 4'h4;
    localparam logic [3:0]  ADDR_MOVE_DELAY  = 4'h5;
    localparam logic [3:0]  ADDR_STATUS      = 4'h6;
    localparam logic [3:0]  ADDR_ANGLE       = 4'h7;

    localparam int unsigned CTRL_FEATURE_BIT = 0;
    localparam int unsigned CTRL_DIR_BIT     = 1;
    localparam logic [1:0]  CTRL_RESET       = 2'h1;

    typedef enum logic [2:0] {
        CASS_IDLE  = 3'b000,
        CASS_RAMP1 = 3'b001,
        CASS_LOCK  = 3'b010,
        CASS_MOVE  = 3'b011,
        CASS_HOLD  = 3'b100,
        CASS_RAMP2 = 3'b101,
        CASS_DONE  = 3'b110
    } cass_state_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cass_bus_req_t;

    typedef struct packed {
        logic        feature_en;
        logic        dir;
        logic [6:0]  current_pct;
        logic [31:0] lock_time;
        logic [31:0] lock_delay;
        logic [31:0] move_time;
        logic [31:0] move_delay;
    } cass_cfg_t;

    typedef struct packed {
        cass_cfg_t   cfg;
        cass_state_t state;
        logic [31:0] count;
        logic        pending;
        logic        link_seen;
        logic        link_lost;
        logic        motion_prev;
        logic [15:0] angle;
        logic        angle_valid;
        logic        starting;
        logic        done;
        logic        refused;
        logic [6:0]  cur_cmd;
        logic        move_act;
        logic        move_dir;
        logic [31:0] rdata;
    } cass_state_reg_t;

endpackage : cass_pkg
`default_nettype wire

// ### core/cass_sequencer.sv
// Functional notes
// - Sequence finds rotor angle without Hall signals.
// - Hall inputs ignored while finding angle.
// - Auto start at power-up and each enable.
// - Rerun after link returns and motion commanded.
// - Default phases total about five seconds.
// - Axis held in starting state throughout.
// - Phases: ramp, lock, move, hold, ramp.
// - Current is percent of peak, default 100.
// - Direction 0 forward, 1 reverse only.
// - Ramp time programmable, default one second.
// - Lock delay programmable, default one second.
// - Move time programmable, default one second.
// - Move hold delay programmable, default one second.
// - Refuse enable for unknown uncatalogued motor.
// - Enable request enters the starting state.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module cass_sequencer (
    input  wire logic        sys_clk,          // System clock, 100 MHz.
    input  wire logic        reset,            // Synchronous reset, active high.
    input  wire logic [3:0]  reg_addr,         // Register word address.
    input  wire logic [31:0] reg_wdata,        // Register write data.
    input  wire logic        reg_wr,           // Write strobe.
    input  wire logic        reg_rd,           // Read strobe.
    output logic      [31:0] reg_rdata,        // Read data, cycle after strobe.
    input  wire logic        enable_req,       // Axis enable request level.
    input  wire logic        link_up,          // Controller connection present.
    input  wire logic        motion_cmd,       // Motion commanded level.
    input  wire logic        offset_known,     // Commutation offset is known.
    input  wire logic        motor_catalogued, // Motor is a catalogued motor.
    input  wire logic [2:0]  hall_in,          // Hall signals, never used here.
    input  wire logic [15:0] enc_angle,        // Encoder electrical angle.
    output logic      [6:0]  current_cmd,      // Current command, percent of peak.
    output logic             move_active,      // Verification move in progress.
    output logic             move_dir,         // Move sense, 0 forward.
    output logic             axis_starting,    // Axis in starting state.
    output logic             seq_done,         // Sequence completed.
    output logic             enable_refused,   // Enable refused.
    output logic      [15:0] angle_out,        // Latched electrical angle.
    output logic             angle_valid       // Latched angle is valid.
);

    cass_pkg::cass_state_reg_t st_ff;
    cass_pkg::cass_state_reg_t nxt_st;
    cass_pkg::cass_bus_req_t   bus;
    logic                      hall_unused;
    logic                      allowed;
    logic                      start_evt;
    logic [31:0]               ramp_num;
    logic [31:0]               phase_len;
    logic [38:0]               ramp_prod;
    logic [38:0]               ramp_div;

    assign bus         = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign hall_unused = ^hall_in;
    assign allowed     = offset_known | motor_catalogued;

    always_comb begin
        nxt_st    = st_ff;
        start_evt = 1'b0;
        phase_len = 32'h0;
        ramp_num  = 32'h0;
        ramp_prod = 39'h0;
        ramp_div  = 39'h0;

        if (bus.wr) begin
            case (bus.addr)
                cass_pkg::ADDR_CTRL: begin
                    nxt_st.cfg.feature_en = bus.wdata[cass_pkg::CTRL_FEATURE_BIT];
                    nxt_st.cfg.dir        = bus.wdata[cass_pkg::CTRL_DIR_BIT];
                end
                cass_pkg::ADDR_CURRENT: begin
                    if (bus.wdata[6:0] > cass_pkg::CURRENT_MAX_PCT) begin
                        nxt_st.cfg.current_pct = cass_pkg::CURRENT_MAX_PCT;
                    end else begin
                        nxt_st.cfg.current_pct = bus.wdata[6:0];
                    end
                end
                cass_pkg::ADDR_LOCK_TIME:  nxt_st.cfg.lock_time  = bus.wdata;
                cass_pkg::ADDR_LOCK_DELAY: nxt_st.cfg.lock_delay = bus.wdata;
                cass_pkg::ADDR_MOVE_TIME:  nxt_st.cfg.move_time  = bus.wdata;
                cass_pkg::ADDR_MOVE_DELAY: nxt_st.cfg.move_delay = bus.wdata;
                default: begin
                end
            endcase
        end

        nxt_st.rdata = 32'h0;
        if (bus.rd) begin
            case (bus.addr)
                cass_pkg::ADDR_CTRL: begin
                    nxt_st.rdata = {30'h0, st_ff.cfg.dir, st_ff.cfg.feature_en};
                end
                cass_pkg::ADDR_CURRENT:    nxt_st.rdata = {25'h0, st_ff.cfg.current_pct};
                cass_pkg::ADDR_LOCK_TIME:  nxt_st.rdata = st_ff.cfg.lock_time;
                cass_pkg::ADDR_LOCK_DELAY: nxt_st.rdata = st_ff.cfg.lock_delay;
                cass_pkg::ADDR_MOVE_TIME:  nxt_st.rdata = st_ff.cfg.move_time;
                cass_pkg::ADDR_MOVE_DELAY: nxt_st.rdata = st_ff.cfg.move_delay;
                cass_pkg::ADDR_STATUS: begin
                    nxt_st.rdata = {24'h0, st_ff.refused, st_ff.angle_valid, st_ff.done,
                                    st_ff.starting, 1'b0, st_ff.state};
                end
                cass_pkg::ADDR_ANGLE: nxt_st.rdata = {16'h0, st_ff.angle};
                default: nxt_st.rdata = 32'h0;
            endcase
        end

        // Track controller connection; a loss after power-up arms a rerun.
        nxt_st.motion_prev = motion_cmd;
        if (link_up) begin
            nxt_st.link_seen = 1'b1;
        end else if (st_ff.link_seen) begin
            nxt_st.link_lost = 1'b1;
        end
        if (st_ff.link_lost && link_up && motion_cmd && !st_ff.motion_prev) begin
            nxt_st.link_lost   = 1'b0;
            nxt_st.angle_valid = 1'b0;
            start_evt          = 1'b1;
        end

        if (!enable_req) begin
            nxt_st.pending = 1'b0;
        end else if (!st_ff.angle_valid) begin
            nxt_st.pending = 1'b1;
        end
        nxt_st.refused = enable_req & ~allowed;

        case (st_ff.state)
            cass_pkg::CASS_RAMP1: phase_len = st_ff.cfg.lock_time;
            cass_pkg::CASS_LOCK:  phase_len = st_ff.cfg.lock_delay;
            cass_pkg::CASS_MOVE:  phase_len = st_ff.cfg.move_time;
            cass_pkg::CASS_HOLD:  phase_len = st_ff.cfg.move_delay;
            cass_pkg::CASS_RAMP2: phase_len = st_ff.cfg.lock_time;
            default:              phase_len = 32'h0;
        endcase

        // Linear ramp of current up to the configured level.
        ramp_num = (phase_len == 32'h0) ? 32'h1 : phase_len;
        ramp_prod = {32'h0, st_ff.cfg.current_pct} * {7'h0, st_ff.count};
        ramp_div  = ramp_prod / {7'h0, ramp_num};

        nxt_st.count    = st_ff.count + 32'h1;
        nxt_st.move_act = 1'b0;
        nxt_st.move_dir = st_ff.cfg.dir;

        case (st_ff.state)
            cass_pkg::CASS_IDLE: begin
                nxt_st.count    = 32'h0;
                nxt_st.cur_cmd  = 7'h0;
                nxt_st.starting = 1'b0;
                if (enable_req && allowed && st_ff.cfg.feature_en &&
                    (st_ff.pending || start_evt) && !st_ff.angle_valid) begin
                    nxt_st.state    = cass_pkg::CASS_RAMP1;
                    nxt_st.starting = 1'b1;
                    nxt_st.done     = 1'b0;
                end else if (enable_req && allowed && st_ff.angle_valid) begin
                    nxt_st.done = 1'b1;
                end
            end
            cass_pkg::CASS_RAMP1, cass_pkg::CASS_RAMP2: begin
                nxt_st.cur_cmd = ramp_div[6:0];
                if (st_ff.count >= phase_len) begin
                    nxt_st.count   = 32'h0;
                    nxt_st.cur_cmd = st_ff.cfg.current_pct;
                    nxt_st.state   = (st_ff.state == cass_pkg::CASS_RAMP1) ?
                                     cass_pkg::CASS_LOCK : cass_pkg::CASS_DONE;
                end
            end
            cass_pkg::CASS_LOCK: begin
                nxt_st.cur_cmd = st_ff.cfg.current_pct;
                if (st_ff.count >= phase_len) begin
                    nxt_st.count = 32'h0;
                    nxt_st.angle = enc_angle;
                    nxt_st.state = cass_pkg::CASS_MOVE;
                end
            end
            cass_pkg::CASS_MOVE: begin
                nxt_st.cur_cmd  = st_ff.cfg.current_pct;
                nxt_st.move_act = 1'b1;
                if (st_ff.count >= phase_len) begin
                    nxt_st.count    = 32'h0;
                    nxt_st.move_act = 1'b0;
                    nxt_st.state    = cass_pkg::CASS_HOLD;
                end
            end
            cass_pkg::CASS_HOLD: begin
                nxt_st.cur_cmd = st_ff.cfg.current_pct;
                if (st_ff.count >= phase_len) begin
                    nxt_st.count   = 32'h0;
                    nxt_st.cur_cmd = 7'h0;
                    nxt_st.state   = cass_pkg::CASS_RAMP2;
                end
            end
            cass_pkg::CASS_DONE: begin
                nxt_st.count       = 32'h0;
                nxt_st.cur_cmd     = 7'h0;
                nxt_st.angle_valid = 1'b1;
                nxt_st.done        = 1'b1;
                nxt_st.starting    = 1'b0;
                nxt_st.pending     = 1'b0;
                nxt_st.state       = cass_pkg::CASS_IDLE;
            end
            default: begin
                nxt_st.state = cass_pkg::CASS_IDLE;
            end
        endcase

        // Withdrawal of enable aborts any phase and drops the angle, so the next enable reruns.
        if (!enable_req) begin
            nxt_st.state    = cass_pkg::CASS_IDLE;
            nxt_st.cur_cmd  = 7'h0;
            nxt_st.move_act = 1'b0;
            nxt_st.starting = 1'b0;
            nxt_st.done     = 1'b0;
            nxt_st.count    = 32'h0;
            nxt_st.angle_valid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_ff                 <= '0;
            st_ff.cfg.feature_en  <= cass_pkg::CTRL_RESET[cass_pkg::CTRL_FEATURE_BIT];
            st_ff.cfg.dir         <= cass_pkg::DIR_DEF;
            st_ff.cfg.current_pct <= cass_pkg::CURRENT_DEF_PCT;
            st_ff.cfg.lock_time   <= cass_pkg::PHASE_DEF_CYC;
            st_ff.cfg.lock_delay  <= cass_pkg::PHASE_DEF_CYC;
            st_ff.cfg.move_time   <= cass_pkg::PHASE_DEF_CYC;
            st_ff.cfg.move_delay  <= cass_pkg::PHASE_DEF_CYC;
            st_ff.state           <= cass_pkg::CASS_IDLE;
            st_ff.pending         <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata      = st_ff.rdata;
    assign current_cmd    = st_ff.cur_cmd;
    assign move_active    = st_ff.move_act;
    assign move_dir       = st_ff.move_dir;
    assign axis_starting  = st_ff.starting;
    assign seq_done       = st_ff.done;
    assign enable_refused = st_ff.refused;
    assign angle_out      = st_ff.angle;
    assign angle_valid    = st_ff.angle_valid;

endmodule // cass_sequencer

`default_nettype wire

// ### tb/cass_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cass_chk (
    input wire logic       sys_clk,          // Clock.
    input wire logic       reset,            // Reset.
    input wire logic       enable_req,       // Enable.
    input wire logic       offset_known,     // Offset known.
    input wire logic       motor_catalogued, // Catalogued.
    input wire logic [6:0] current_cmd,      // Current.
    input wire logic       move_active,      // Move phase.
    input wire logic       move_dir,         // Move sense.
    input wire logic       axis_starting,    // Starting.
    input wire logic       seq_done,         // Done.
    input wire logic       enable_refused,   // Refused.
    input wire logic       angle_valid       // Valid.
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_abort; axis_starting && !enable_req; endsequence
    sequence s_idle; !axis_starting && current_cmd == 7'h00 && !angle_valid; endsequence
    property p_abort; s_abort |=> s_idle; endproperty
    a_abort: assert property (p_abort) else $error("abort left current on");
    property p_refuse;
        1'b1 |=> enable_refused == $past(enable_req && !(offset_known || motor_catalogued));
    endproperty
    a_refuse: assert property (p_refuse) else $error("refusal flag wrong");
    property p_excl; !(axis_starting && seq_done); endproperty
    a_excl: assert property (p_excl) else $error("done while starting");
    property p_leave; $fell(axis_starting) |-> seq_done || !$past(enable_req); endproperty
    a_leave: assert property (p_leave) else $error("left starting early");
    property p_done; $rose(seq_done) |-> angle_valid && !axis_starting; endproperty
    a_done: assert property (p_done) else $error("done without angle");
    property p_dir; move_active && $past(move_active) |-> $stable(move_dir); endproperty
    a_dir: assert property (p_dir) else $error("sense changed in move");
    property p_cap; current_cmd <= cass_pkg::CURRENT_MAX_PCT; endproperty
    a_cap: assert property (p_cap) else $error("current above peak");
    property p_start; $rose(axis_starting) |-> $past(enable_req) && !enable_refused; endproperty
    a_start: assert property (p_start) else $error("start without enable");
endmodule // cass_chk
bind cass_sequencer cass_chk cass_chk_i (.sys_clk(sys_clk), .reset(reset),
    .enable_req(enable_req), .offset_known(offset_known), .motor_catalogued(motor_catalogued),
    .current_cmd(current_cmd), .move_active(move_active), .move_dir(move_dir),
    .axis_starting(axis_starting), .seq_done(seq_done), .enable_refused(enable_refused),
    .angle_valid(angle_valid));
`default_nettype wire

// ### tb/cass_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module cass_motor_model #(
    parameter logic [15:0] START_ANGLE = 16'h2A5C // Rotor angle at power-up.
) (
    input  wire logic       sys_clk,     // Clock.
    input  wire logic [6:0] current_cmd, // Phase current.
    input  wire logic       move_active, // Move phase.
    input  wire logic       move_dir,    // Move sense.
    output logic     [15:0] enc_angle,   // Encoder angle.
    output logic     [2:0]  hall_in      // Hall lines.
);
    logic [15:0] pos_ff = START_ANGLE;
    logic [2:0]  hall_ff = 3'h5;
    // The rotor turns one count a cycle, only while move_active with current on; that step is its speed ceiling.
    // Hall lines churn as noise.
    always_ff @(posedge sys_clk) begin
        if (move_active && current_cmd != 7'h00) begin
            pos_ff <= move_dir ? pos_ff - 16'h1 : pos_ff + 16'h1;
        end
        hall_ff <= hall_ff + 3'h3;
    end
    assign enc_angle = pos_ff;
    assign hall_in   = hall_ff;
endmodule // cass_motor_model
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %0t got %0h want %0h", $time, got, exp); end end
module tb;
    typedef struct packed {logic dir; logic [6:0] cur_wr; logic [6:0] cur_exp;} cass_row_t;
    localparam cass_row_t ROWS [3] = '{'{1'h0, 7'h32, 7'h32}, '{1'h1, 7'h64, 7'h64},
                                       '{1'h0, 7'h7F, 7'h64}};
    localparam logic [3:0] PH [5] = '{4'h2, 4'h2, 4'h3, 4'h4, 4'h5};
    localparam int SEQ_LEN = 37;
    logic sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, enable_req = 1'b0;
    logic link_up = 1'b1, motion_cmd = 1'b0, offset_known = 1'b1, motor_catalogued = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rv, acc;
    logic [15:0] enc_angle, angle_out, pre;
    logic [6:0]  current_cmd, cur_mv;
    logic [2:0]  hall_in;
    logic move_active, move_dir, axis_starting, seq_done, enable_refused, angle_valid, dir_mv;
    int bad_count = 0, check_count = 0, n_st = 0, n_mv = 0;
    initial forever #5 sys_clk = ~sys_clk;
    cass_sequencer cass_sequencer_i (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .enable_req(enable_req), .link_up(link_up), .motion_cmd(motion_cmd),
        .offset_known(offset_known), .motor_catalogued(motor_catalogued), .hall_in(hall_in),
        .enc_angle(enc_angle), .current_cmd(current_cmd), .move_active(move_active),
        .move_dir(move_dir), .axis_starting(axis_starting), .seq_done(seq_done),
        .enable_refused(enable_refused), .angle_out(angle_out), .angle_valid(angle_valid));
    cass_motor_model cass_motor_model_i (.sys_clk(sys_clk), .current_cmd(current_cmd),
        .move_active(move_active), .move_dir(move_dir), .enc_angle(enc_angle), .hall_in(hall_in));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    // Resets, loads short phase times (4, 6, 8, 10 cycles) and raises enable.
    task automatic start(input logic dir, input logic [6:0] cur);
        @(posedge sys_clk);
        reset <= 1'b1;
        enable_req <= 1'b0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        bus(1'b1, cass_pkg::ADDR_CTRL, {30'h0, dir, 1'b1});
        bus(1'b1, cass_pkg::ADDR_CURRENT, {25'h0, cur});
        for (int i = 2; i < 6; i++) bus(1'b1, 4'(i), 32'(2 * i));
        pre = enc_angle;
        n_st = 0;
        n_mv = 0;
        @(posedge sys_clk);
        enable_req <= 1'b1;
    endtask
    task automatic wait_hi(input int w);
        logic s;
        s = 1'b0;
        for (int i = 0; i < 600 && s !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
            s = (w == 0) ? seq_done : (w == 1) ? move_active : axis_starting;
            if (axis_starting === 1'b1) n_st++;
            if (move_active === 1'b1) begin
                n_mv++;
                cur_mv = current_cmd;
                dir_mv = move_dir;
            end
        end
        if (s !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t wait ran out", $time);
            stop_test();
        end
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        bad_count++;
        $display("[FAIL] %0t run too long", $time);
        stop_test();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        acc = 32'h0;
        foreach (PH[k]) begin
            bus(1'b0, PH[k], 32'h0);
            `CHK(rv, cass_pkg::PHASE_DEF_CYC)
            acc = acc + rv;
        end
        `CHK(acc, 32'(5 * cass_pkg::CLK_HZ))
        bus(1'b0, cass_pkg::ADDR_CTRL, 32'h0);
        `CHK(rv, 32'(cass_pkg::CTRL_RESET))
        bus(1'b0, cass_pkg::ADDR_CURRENT, 32'h0);
        `CHK(rv, 32'(cass_pkg::CURRENT_DEF_PCT))
        bus(1'b0, 4'hF, 32'h0);
        `CHK(rv, 32'h0)
        for (int r = 0; r < 3; r++) begin
            start(ROWS[r].dir, ROWS[r].cur_wr);
            wait_hi(0);
            `CHK(n_st >= SEQ_LEN && n_st <= SEQ_LEN + 2, 1'b1)
            `CHK(n_mv, 8)
            `CHK(cur_mv, ROWS[r].cur_exp)
            `CHK(dir_mv, ROWS[r].dir)
            `CHK(enc_angle, ROWS[r].dir ? pre - 16'h8 : pre + 16'h8)
            `CHK({angle_valid, axis_starting, angle_out}, {2'h2, pre})
            bus(1'b0, cass_pkg::ADDR_ANGLE, 32'h0);
            `CHK(rv, {16'h0, pre})
            bus(1'b0, cass_pkg::ADDR_STATUS, 32'h0);
            `CHK(rv, 32'h60)
        end
        @(posedge sys_clk);
        enable_req <= 1'b0;
        @(posedge sys_clk);
        enable_req <= 1'b1;
        wait_hi(2);
        wait_hi(0);
        `CHK(angle_out, enc_angle - 16'h8)
        @(posedge sys_clk);
        link_up <= 1'b0;
        @(posedge sys_clk);
        link_up <= 1'b1;
        @(posedge sys_clk);
        motion_cmd <= 1'b1;
        wait_hi(2);
        wait_hi(0);
        `CHK(angle_valid, 1'b1)
        @(posedge sys_clk);
        offset_known <= 1'b0;
        start(1'h0, 7'h64);
        repeat (20) @(posedge sys_clk);
        #1;
        `CHK({axis_starting, enable_refused}, 2'h1)
        @(posedge sys_clk);
        motor_catalogued <= 1'b1;
        wait_hi(0);
        `CHK(angle_out, pre)
        start(1'h1, 7'h64);
        wait_hi(1);
        @(posedge sys_clk);
        enable_req <= 1'b0;
        @(posedge sys_clk);
        #1;
        `CHK({axis_starting, current_cmd, angle_valid}, 9'h000)
        bus(1'b1, cass_pkg::ADDR_CTRL, 32'h0);
        @(posedge sys_clk);
        enable_req <= 1'b1;
        repeat (20) @(posedge sys_clk);
        #1;
        `CHK({axis_starting, seq_done}, 2'h0)
        stop_test();
    end
endmodule // tb
`default_nettype wire
